// *** logic/srg_pkg.sv ***
package srg_pkg;

  // timebase
  localparam int unsigned CLK_FREQ_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;

  // release hold time build options, in microseconds
  localparam int unsigned HOLD_SHORT_US = 2190;
  localparam int unsigned HOLD_MID_US = 35000;
  localparam int unsigned HOLD_LONG_US = 280000;
  localparam int unsigned HOLD_SHORT_CYC = HOLD_SHORT_US * 20;
  localparam int unsigned HOLD_MID_CYC = HOLD_MID_US * 20;
  localparam int unsigned HOLD_LONG_CYC = HOLD_LONG_US * 20;

  // manual input glitch filter width, least time rounds up
  localparam int unsigned GLITCH_NS = 100;
  localparam int unsigned GLITCH_CYC =
    (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // button qualify time (no printed figure), in microseconds
  localparam int unsigned QUALIFY_US = 10;
  localparam int unsigned QUALIFY_CYC = QUALIFY_US * 20;

  // supply dip duration needed to count as a brown-out, in ns
  localparam int unsigned DIP_NS = 1000;
  localparam int unsigned DIP_CYC =
    (DIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // hold-time selections
  localparam logic [1:0] HOLD_SEL_SHORT = 2'h0;
  localparam logic [1:0] HOLD_SEL_MID = 2'h1;
  localparam logic [1:0] HOLD_SEL_LONG = 2'h2;

  // output style selections
  localparam logic [1:0] OUT_PP_LOW = 2'h0;
  localparam logic [1:0] OUT_OD_LOW = 2'h1;
  localparam logic [1:0] OUT_PP_HIGH = 2'h2;

  localparam int unsigned CNT_W = 24;

  typedef enum logic [1:0] {
    SRG_HOLD = 2'b00,
    SRG_DELAY = 2'b01,
    SRG_RUN = 2'b11
  } srg_state_e;

endpackage : srg_pkg

// *** logic/srg_qualifier.sv ***
`timescale 1ns/1ps
// reports a level only after it has held for QUAL_CYC cycles in a row;
// any break restarts the count
module srg_qualifier
  import srg_pkg::*;
#(
  parameter int unsigned QUAL_CYC = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic level_in,
  output logic qualified
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic qual_r;
  logic qual_nxt;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(QUAL_CYC - 1);

  always_comb begin
    cnt_nxt = '0;
    qual_nxt = 1'b0;
    if (level_in) begin
      if (cnt_r >= LAST) begin
        cnt_nxt = cnt_r;
        qual_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
      qual_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      qual_r <= qual_nxt;
    end
  end

  assign qualified = qual_r;

endmodule : srg_qualifier

// *** logic/srg_generator.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module srg_generator
  import srg_pkg::*;
#(
  parameter logic [1:0] HOLD_SEL = HOLD_SEL_LONG,
  parameter logic [1:0] OUT_STYLE = OUT_PP_LOW,
  parameter int unsigned QUALIFY_CYCLES = QUALIFY_CYC,
  parameter int unsigned HOLD_CYCLES_SHORT = HOLD_SHORT_CYC,
  parameter int unsigned HOLD_CYCLES_MID = HOLD_MID_CYC,
  parameter int unsigned HOLD_CYCLES_LONG = HOLD_LONG_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic supply_low,
  input wire logic manual_reset_in_n,
  input wire logic manual_reset_in_n_oe,
  output logic reset_out,
  output logic reset_out_oe
);

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned HOLD_CYC_SEL =
    (HOLD_SEL == HOLD_SEL_SHORT) ? HOLD_CYCLES_SHORT :
    (HOLD_SEL == HOLD_SEL_MID) ? HOLD_CYCLES_MID : HOLD_CYCLES_LONG;
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC_SEL - 1);
  localparam logic ACTIVE_LVL = (OUT_STYLE == OUT_PP_HIGH);

  logic mr_low;
  logic mr_filt;
  logic mr_qual;
  logic uv_qual;
  logic request;

  // an undriven manual pin reads as released, like the internal pull-up
  assign mr_low = manual_reset_in_n_oe & ~manual_reset_in_n;

  // spike filter, then the longer button qualify time; chained so the
  // qualify count only starts once the level is known not to be a glitch
  srg_qualifier #(.QUAL_CYC(GLITCH_CYC)) u_glitch (
    .clk(clk),
    .reset(reset),
    .level_in(mr_low),
    .qualified(mr_filt)
  );

  srg_qualifier #(.QUAL_CYC(QUALIFY_CYCLES)) u_button (
    .clk(clk),
    .reset(reset),
    .level_in(mr_filt),
    .qualified(mr_qual)
  );

  // comparator output must persist before it counts as a brown-out
  srg_qualifier #(.QUAL_CYC(DIP_CYC)) u_dip (
    .clk(clk),
    .reset(reset),
    .level_in(supply_low),
    .qualified(uv_qual)
  );

  assign request = uv_qual | mr_qual;

  ////////////////////////////////////////////////////////////////////////////
  srg_state_e state_r;
  srg_state_e state_nxt;
  logic [CNT_W-1:0] tmr_r;
  logic [CNT_W-1:0] tmr_nxt;
  logic act_r;
  logic act_nxt;

  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    act_nxt = 1'b1;
    case (state_r)
      SRG_HOLD: begin
        tmr_nxt = '0;
        if (!request) begin
          state_nxt = SRG_DELAY;
        end
      end
      SRG_DELAY: begin
        if (request) begin
          state_nxt = SRG_HOLD;
          tmr_nxt = '0;
        end else if (tmr_r >= HOLD_LAST) begin
          state_nxt = SRG_RUN;
          act_nxt = 1'b0;
        end else begin
          tmr_nxt = tmr_r + CNT_W'(1);
        end
      end
      SRG_RUN: begin
        act_nxt = 1'b0;
        if (request) begin
          state_nxt = SRG_HOLD;
          act_nxt = 1'b1;
          tmr_nxt = '0;
        end
      end
      default: begin
        state_nxt = SRG_HOLD;
        tmr_nxt = '0;
      end
    endcase
  end
  // act_r stays set through hold and delay

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= SRG_HOLD;
      tmr_r <= '0;
      act_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      act_r <= act_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic out_r;
  logic oe_r;
  logic out_nxt;
  logic oe_nxt;

  always_comb begin
    out_nxt = act_nxt ? ACTIVE_LVL : ~ACTIVE_LVL;
    oe_nxt = 1'b1;
    if (OUT_STYLE == OUT_OD_LOW) begin
      out_nxt = 1'b0;
      oe_nxt = act_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_r <= (OUT_STYLE == OUT_PP_HIGH);
      oe_r <= 1'b1;
    end else begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign reset_out = out_r;
  assign reset_out_oe = oe_r;

endmodule : srg_generator

// *** testbench/srg_assertions.sv ***
`timescale 1ns/1ps
module srg_assertions
  import srg_pkg::*;
#(
  parameter int unsigned HOLD = 60,
  parameter logic [1:0] STYLE = OUT_PP_LOW
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic supply_low,
  input wire logic manual_reset_in_n,
  input wire logic manual_reset_in_n_oe,
  input wire logic reset_out,
  input wire logic reset_out_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // act: reset asserted on the pin, whatever the build's output style
  logic act;
  assign act = (STYLE == OUT_OD_LOW) ? reset_out_oe :
    (reset_out == (STYLE == OUT_PP_HIGH));
  // clean_r: cycles since both conditions cleared, saturating
  logic [7:0] clean_r, clean_nxt, low_r, low_nxt;
  always_comb begin
    clean_nxt = clean_r + {7'h0, clean_r != 8'hff};
    if (supply_low || !manual_reset_in_n) clean_nxt = 8'h00;
    low_nxt = supply_low ? low_r + {7'h0, low_r != 8'hff} : 8'h00;
  end
  always_ff @(posedge clk) begin
    clean_r <= reset ? 8'h00 : clean_nxt;
    low_r <= reset ? 8'h00 : low_nxt;
  end
  sequence short_dip;
    !act && !supply_low ##1 supply_low[*5] ##1 !supply_low[*4];
  endsequence
  sequence spike;
    !act && manual_reset_in_n ##1 !manual_reset_in_n ##1
      manual_reset_in_n[*6];
  endsequence
  oe_driven_a: assert property ((STYLE == OUT_OD_LOW) ? !reset_out :
      reset_out_oe)
    else $error("output driver style broken");
  uv_keep_a: assert property (act && supply_low |=> act)
    else $error("output released under undervoltage");
  man_keep_a: assert property (act && !manual_reset_in_n |=> act)
    else $error("output released while button held");
  dip_reject_a: assert property (short_dip |-> !act)
    else $error("short supply dip caused reset");
  spike_reject_a: assert property (spike |-> !act)
    else $error("button spike caused reset");
  uv_trip_a: assert property (low_r == 8'h18 |-> act)
    else $error("lasting undervoltage not reported");
  man_trip_a: assert property (!manual_reset_in_n[*8] ##1
      !manual_reset_in_n[*5] |-> act)
    else $error("held button not reported");
  rel_min_a: assert property ($fell(act) |-> clean_r >= HOLD)
    else $error("release before full delay");
  rel_max_a: assert property (clean_r == HOLD + 8 |-> !act)
    else $error("release late after conditions cleared");
endmodule : srg_assertions

// *** testbench/srg_button.sv ***
`timescale 1ns/1ps
// button released means pin floats; the pull-up makes it read high
module srg_button (
  input wire logic press,
  output logic pin_n,
  output logic pin_oe
);
  assign pin_oe = press;
  assign pin_n = !press;
endmodule : srg_button

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb
  import srg_pkg::*;
;
  localparam int H = 60;
  logic clk, reset, supply_low, press, pin_n, pin_oe, reset_out, oe;
  logic od_out, od_oe;
  int num_errors = 0;
  int n_tests = 0;
  srg_button btn (.press(press), .pin_n(pin_n), .pin_oe(pin_oe));
  srg_generator #(.HOLD_SEL(HOLD_SEL_MID), .OUT_STYLE(OUT_PP_LOW),
    .QUALIFY_CYCLES(4), .HOLD_CYCLES_SHORT(50), .HOLD_CYCLES_MID(H),
    .HOLD_CYCLES_LONG(70)) dut (.clk(clk), .reset(reset),
    .supply_low(supply_low), .manual_reset_in_n(pin_n),
    .manual_reset_in_n_oe(pin_oe), .reset_out(reset_out),
    .reset_out_oe(oe));
  // open-drain build on the same inputs: pin floats once released
  srg_generator #(.HOLD_SEL(HOLD_SEL_MID), .OUT_STYLE(OUT_OD_LOW),
    .QUALIFY_CYCLES(4), .HOLD_CYCLES_SHORT(50), .HOLD_CYCLES_MID(H),
    .HOLD_CYCLES_LONG(70)) dut_od (.clk(clk), .reset(reset),
    .supply_low(supply_low), .manual_reset_in_n(pin_n),
    .manual_reset_in_n_oe(pin_oe), .reset_out(od_out),
    .reset_out_oe(od_oe));
  always #25 clk = !clk;
  task chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task step(input logic sl, input logic pr, input int n);
    @(posedge clk) begin
      supply_low <= sl;
      press <= pr;
    end
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // full delay counted from the edge that cleared the last condition
  task rel();
    step(0, 0, H);
    chk(reset_out, 0);
    chk(od_oe, 1);
    step(0, 0, 10);
    chk(reset_out, 1);
    chk(od_oe, 0);
    chk(od_out, 0);
  endtask : rel
  task t_power();
    step(1, 0, 40);
    chk(reset_out, 0);
    rel();
  endtask : t_power
  task t_dip();
    step(1, 0, 4);
    step(0, 0, 5);
    chk(reset_out, 1);
    step(1, 0, 30);
    chk(reset_out, 0);
    rel();
  endtask : t_dip
  task t_man();
    step(0, 1, 0);
    step(0, 0, 12);
    chk(reset_out, 1);
    step(0, 1, 40);
    chk(reset_out, 0);
    rel();
  endtask : t_man
  task t_restart();
    step(1, 0, 30);
    step(0, 0, 30);
    chk(reset_out, 0);
    step(0, 1, 15);
    rel();
  endtask : t_restart
  task print_verdict();
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 0;
    reset = 1;
    supply_low = 1;
    press = 0;
    repeat (16) @(posedge clk);
    reset <= 0;
    #1;
    chk(reset_out, 0);
    chk(od_oe, 1);
    t_power();
    t_dip();
    t_man();
    t_restart();
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule : tb
bind srg_generator srg_assertions #(.HOLD(60), .STYLE(OUT_STYLE)) chk_i (
  .clk(clk),
  .reset(reset), .supply_low(supply_low),
  .manual_reset_in_n(manual_reset_in_n),
  .manual_reset_in_n_oe(manual_reset_in_n_oe), .reset_out(reset_out),
  .reset_out_oe(reset_out_oe));
